//--- rtl/cfh_pkg.sv
// Shared constants and types of the chirp frame header generator.
// Notes on behaviour
// - A frame goes out as preamble, then delimiter, then PHY header, and only then the payload.
// - At 1 Mb/s the preamble is 32 one bits, making 8 chirp symbols.
// - At 250 kb/s the preamble is 80 one bits, making 20 chirp symbols.
// - Each preamble bit is driven unchanged on both the I and the Q mapper input.
// - The 16-bit delimiter is chosen by the active rate and each bit is driven on both I and Q.
// - The delimiter is sent from bit 0 upward through bit 15.
// - The 1 Mb/s delimiter is -1 1 1 1 -1 1 -1 -1 1 -1 -1 1 1 1 -1 -1 from bit 0.
// - The 250 kb/s delimiter is -1 1 1 1 1 -1 1 -1 -1 -1 -1 -1 -1 -1 1 1 from bit 0.
// - The 12-bit PHY header holds the payload length in bits 0 to 6, unused bits 7 and 8, reserved 9 to 11.
// - The 1 Mb/s mode uses 8-ary coding and the 250 kb/s mode 64-ary coding, with DQPSK.
// - The 1 Mb/s mode is always present; the 250 kb/s mode may be left out.
package cfh_pkg;

    typedef enum logic [2:0] {
        CFH_IDLE = 3'b000,
        CFH_PRE  = 3'b001,
        CFH_SFD  = 3'b010,
        CFH_PHR  = 3'b011,
        CFH_PAY  = 3'b100
    } cfh_state_t;

    localparam int unsigned CNT_W        = 7;
    localparam logic [6:0]  PRE_LEN_1M   = 7'h20;
    localparam logic [6:0]  PRE_LEN_250K = 7'h50;
    localparam logic [6:0]  SFD_LEN      = 7'h10;
    localparam logic [6:0]  PHR_LEN      = 7'h0C;
    localparam int unsigned LEN_W        = 7;
    localparam int unsigned PHR_W        = 12;
    localparam int unsigned PHR_LEN_LSB  = 0;
    localparam logic [4:0]  PHR_PAD      = 5'h00;
    // Bit 0 sits in the LSB; a one bit stands for +1, a zero bit for -1.
    localparam logic [15:0] SFD_1M       = 16'h392E;
    localparam logic [15:0] SFD_250K     = 16'hC05E;
    // Coding order of the data path: 3 bits per symbol at 1 Mb/s, 6 at 250 kb/s.
    localparam logic [2:0]  SYM_BITS_1M   = 3'h3;
    localparam logic [2:0]  SYM_BITS_250K = 3'h6;
    localparam logic        RESET_BIT     = 1'h0;

endpackage

//--- rtl/cfh_hdr_if.sv
// Header word and rate carried from the frame sequencer to the header store.
`timescale 1ns/10ps
`default_nettype none
interface cfh_hdr_if;
    logic        load;
    logic        slow;
    logic [6:0]  len;
    logic [3:0]  idx;
    logic        bit_out;
    logic [15:0] sfd;
    modport seq (output load, output slow, output len, output idx, input bit_out, input sfd);
    modport store (input load, input slow, input len, input idx, output bit_out, output sfd);
endinterface
`default_nettype wire

//--- rtl/cfh_hdr_store.sv
// Latched PHY header and delimiter for the frame in flight.
`timescale 1ns/10ps
`default_nettype none
module cfh_hdr_store (
    input  wire logic mclk,
    input  wire logic resetn,
    cfh_hdr_if.store  hif
);
    logic [11:0] phr_r;
    logic [11:0] phr_nxt;
    logic [15:0] sfd_r;
    logic [15:0] sfd_nxt;
    logic        bit_r;
    logic        bit_nxt;

    always_comb begin
        phr_nxt = phr_r;
        sfd_nxt = sfd_r;
        if (hif.load) begin
            phr_nxt = {cfh_pkg::PHR_PAD, hif.len};
            sfd_nxt = hif.slow ? cfh_pkg::SFD_250K : cfh_pkg::SFD_1M;
        end
        // Indices past the header word read as zero instead of off the end of the register.
        bit_nxt = ({3'h0, hif.idx} < cfh_pkg::PHR_LEN) ? phr_r[hif.idx] : 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            phr_r <= 12'h000;
            sfd_r <= 16'h0000;
            bit_r <= 1'h0;
        end else begin
            phr_r <= phr_nxt;
            sfd_r <= sfd_nxt;
            bit_r <= bit_nxt;
        end
    end

    assign hif.bit_out = bit_r;
    assign hif.sfd     = sfd_r;
endmodule
`default_nettype wire

//--- rtl/cfh_frame_gen.sv
// Frame sequencer: preamble, delimiter and PHY header ahead of the payload.
`timescale 1ns/10ps
`default_nettype none
module cfh_frame_gen #(
    parameter bit SLOW_EN = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       rate_slow,
    input  wire logic [6:0] pay_len,
    input  wire logic       pay_bit,
    input  wire logic       pay_valid,
    output logic            pay_ready,
    output logic            bit_i,
    output logic            bit_q,
    output logic            bit_valid,
    output logic            in_payload,
    output logic            busy,
    output logic            rate_slow_out,
    output logic [2:0]      sym_bits
);
    cfh_hdr_if hif ();

    cfh_hdr_store u_store (
        .mclk   (mclk),
        .resetn (resetn),
        .hif    (hif)
    );

    cfh_pkg::cfh_state_t st_r;
    cfh_pkg::cfh_state_t st_nxt;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic       slow_r;
    logic       slow_nxt;
    logic       bi_r;
    logic       bi_nxt;
    logic       bq_r;
    logic       bq_nxt;
    logic       bv_r;
    logic       bv_nxt;
    logic       pr_r;
    logic       pr_nxt;
    logic       phr_q_r;
    logic       phr_q_nxt;

    // The header bit comes one cycle late from the store register, so the
    // PHY header phase is padded by a one-cycle fetch at its head.
    assign hif.load = (st_r == cfh_pkg::CFH_IDLE) && start;
    assign hif.slow = rate_slow && SLOW_EN;
    assign hif.len  = pay_len;
    assign hif.idx  = cnt_r[3:0];

    // Last preamble count for the latched rate; shared by the sequencer and its check.
    function automatic logic [6:0] pre_last(input logic slow);
        pre_last = (slow ? cfh_pkg::PRE_LEN_250K : cfh_pkg::PRE_LEN_1M) - 7'h01;
    endfunction

    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        slow_nxt  = slow_r;
        bi_nxt    = 1'b0;
        bq_nxt    = 1'b0;
        bv_nxt    = 1'b0;
        pr_nxt    = 1'b0;
        phr_q_nxt = 1'b0;
        case (st_r)
            cfh_pkg::CFH_IDLE: begin
                if (start) begin
                    slow_nxt = rate_slow && SLOW_EN;
                    cnt_nxt  = 7'h00;
                    st_nxt   = cfh_pkg::CFH_PRE;
                end
            end
            cfh_pkg::CFH_PRE: begin
                bi_nxt = 1'b1;
                bq_nxt = 1'b1;
                bv_nxt = 1'b1;
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == pre_last(slow_r)) begin
                    cnt_nxt = 7'h00;
                    st_nxt  = cfh_pkg::CFH_SFD;
                end
            end
            cfh_pkg::CFH_SFD: begin
                bi_nxt = hif.sfd[cnt_r[3:0]];
                bq_nxt = hif.sfd[cnt_r[3:0]];
                bv_nxt = 1'b1;
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == cfh_pkg::SFD_LEN - 7'h01) begin
                    cnt_nxt = 7'h00;
                    st_nxt  = cfh_pkg::CFH_PHR;
                end
            end
            cfh_pkg::CFH_PHR: begin
                phr_q_nxt = 1'b1;
                cnt_nxt = cnt_r + 7'h01;
                if (cnt_r == cfh_pkg::PHR_LEN - 7'h01) begin
                    st_nxt = cfh_pkg::CFH_PAY;
                    cnt_nxt = 7'h00;
                end
            end
            cfh_pkg::CFH_PAY: begin
                pr_nxt = 1'b1;
                if (pay_valid && pr_r) begin
                    bi_nxt = pay_bit;
                    bv_nxt = 1'b1;
                end
                // The length field is informative only: the frame ends on the
                // first bit accepted after start falls, and ready drops with it.
                if (pay_valid && pr_r) begin
                    cnt_nxt = cnt_r + 7'h01;
                    if (!start) begin
                        st_nxt = cfh_pkg::CFH_IDLE;
                        pr_nxt = 1'b0;
                    end
                end
            end
            default: st_nxt = cfh_pkg::CFH_IDLE;
        endcase
        // The header bit arrives a cycle after its index was presented.
        if (phr_q_r) begin
            bi_nxt = hif.bit_out;
            bq_nxt = hif.bit_out;
            bv_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_r    <= cfh_pkg::CFH_IDLE;
            cnt_r   <= 7'h00;
            slow_r  <= 1'b0;
            bi_r    <= 1'b0;
            bq_r    <= 1'b0;
            bv_r    <= 1'b0;
            pr_r    <= 1'b0;
            phr_q_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            slow_r  <= slow_nxt;
            bi_r    <= bi_nxt;
            bq_r    <= bq_nxt;
            bv_r    <= bv_nxt;
            pr_r    <= pr_nxt;
            phr_q_r <= phr_q_nxt;
        end
    end

    logic       busy_r;
    logic       busy_nxt;
    logic       pl_r;
    logic       pl_nxt;
    logic [2:0] sb_r;
    logic [2:0] sb_nxt;

    // Status levels are taken from the next state so they change together with the state.
    always_comb begin
        busy_nxt = (st_nxt != cfh_pkg::CFH_IDLE);
        pl_nxt   = (st_nxt == cfh_pkg::CFH_PAY);
        sb_nxt   = slow_nxt ? cfh_pkg::SYM_BITS_250K : cfh_pkg::SYM_BITS_1M;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            pl_r   <= 1'b0;
            sb_r   <= cfh_pkg::SYM_BITS_1M;
        end else begin
            busy_r <= busy_nxt;
            pl_r   <= pl_nxt;
            sb_r   <= sb_nxt;
        end
    end

    assign bit_i         = bi_r;
    assign bit_q         = bq_r;
    assign bit_valid     = bv_r;
    assign pay_ready     = pr_r;
    assign busy          = busy_r;
    assign in_payload    = pl_r;
    assign rate_slow_out = slow_r;
    assign sym_bits      = sb_r;

    sequence s_sfd_last;
        st_r == cfh_pkg::CFH_SFD && cnt_r == cfh_pkg::SFD_LEN - 7'h01;
    endsequence
    sequence s_phr_gap;
        !bit_valid ##1 bit_valid[*6] ##1 bit_valid[*6];
    endsequence

    a_hdr_gap: assert property (@(posedge mclk) disable iff (!resetn)
        s_sfd_last |=> bit_valid ##1 s_phr_gap)
        else $error("header not one gap cycle then twelve bits after delimiter");
    a_pay_rail: assert property (@(posedge mclk) disable iff (!resetn)
        (st_r == cfh_pkg::CFH_PAY && pay_valid && pay_ready) |=> (bit_valid && !bit_q))
        else $error("accepted payload bit not passed on the I rail");
    a_pre_ones: assert property (@(posedge mclk) disable iff (!resetn)
        (st_r == cfh_pkg::CFH_PRE) |=> (bit_i && bit_q && bit_valid))
        else $error("preamble bit not one on both rails");
    a_pre_len: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(st_r == cfh_pkg::CFH_SFD) |-> $past(cnt_r) == pre_last(slow_r))
        else $error("preamble length wrong");
    a_sfd_iq: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_r == cfh_pkg::CFH_SFD) |-> bit_i == bit_q)
        else $error("delimiter differs on I and Q");
    a_sfd_first: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(st_r == cfh_pkg::CFH_SFD) |=> bit_i == 1'b0)
        else $error("delimiter bit 0 not minus one");
    a_order_seq: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(st_r == cfh_pkg::CFH_PHR) |-> $past(st_r) == cfh_pkg::CFH_SFD)
        else $error("header not after delimiter");
    a_phr_pad: assert property (@(posedge mclk) disable iff (!resetn)
        (phr_q_r && (cnt_r >= 7'h08 || cnt_r == 7'h00)) |=> (!bit_i && !bit_q))
        else $error("padding bit not zero");
    a_slow_off: assert property (@(posedge mclk) disable iff (!resetn)
        (st_r == cfh_pkg::CFH_IDLE && start) |=> slow_r == (SLOW_EN && $past(rate_slow)))
        else $error("rate latched wrongly at frame start");
    a_sym_bits: assert property (@(posedge mclk) disable iff (!resetn)
        busy |-> sym_bits == (slow_r ? 3'h6 : 3'h3))
        else $error("coding order mismatch");
endmodule
`default_nettype wire

//--- dv/cfh_pay_src.sv
// Payload source model standing in for the frame source ahead of the block.
`timescale 1ns/10ps
`default_nettype none
module cfh_pay_src (
    input  wire logic mclk,
    input  wire logic frame_on,
    input  wire logic stall,
    input  wire logic pay_ready,
    output logic      pay_bit,
    output logic      pay_valid
);
    int   k = 0;
    logic took = 1'b0;
    initial pay_valid = 1'b0;
    initial pay_bit = 1'b0;
    always @(posedge mclk) begin
        took <= pay_valid && pay_ready;
        if (!frame_on) k <= 0;
        else if (pay_valid && pay_ready) k <= k + 1;
    end
    // A pending bit is held until taken; stalling only starts between bits.
    always @(negedge mclk) begin
        if (!pay_valid || took) pay_valid <= !stall;
        pay_bit <= k[0] ^ k[1] ^ k[3];
        if (!(pay_valid && !took) && stall) pay_bit <= ~(k[0] ^ k[1] ^ k[3]);
    end
endmodule
`default_nettype wire

//--- dv/css_frame_header_gen_test.sv
// Self-checking bench of the chirp frame header generator.
`timescale 1ns/10ps
`default_nettype none
module css_frame_header_gen_test;
    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       start = 1'b0;
    logic       rate_slow = 1'b0;
    logic [6:0] pay_len = 7'h00;
    logic       stall = 1'b0;
    logic       pay_bit, pay_valid, pay_ready, bit_i, bit_q, bit_valid;
    logic       in_payload, busy, rate_slow_out;
    logic [2:0] sym_bits;
    int         mismatches = 0;
    int         checked = 0;
    always #4 mclk = ~mclk;
    cfh_frame_gen u_cfh_frame_gen (.mclk(mclk), .resetn(resetn), .start(start),
        .rate_slow(rate_slow), .pay_len(pay_len), .pay_bit(pay_bit),
        .pay_valid(pay_valid), .pay_ready(pay_ready), .bit_i(bit_i), .bit_q(bit_q),
        .bit_valid(bit_valid), .in_payload(in_payload), .busy(busy),
        .rate_slow_out(rate_slow_out), .sym_bits(sym_bits));
    cfh_pay_src u_cfh_pay_src (.mclk(mclk), .frame_on(busy), .stall(stall),
        .pay_ready(pay_ready), .pay_bit(pay_bit), .pay_valid(pay_valid));
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (exp !== got) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task get_bit(output logic i, output logic q);
        int n;
        n = 0;
        @(negedge mclk);
        while (bit_valid !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("bit wait", 16'h0000, 16'(n >= 200));
        i = bit_i;
        q = bit_q;
    endtask
    task frame(input logic slow, input logic [6:0] len);
        int   npre;
        int   k;
        logic i, q;
        logic [15:0] sfd;
        logic [11:0] hdr;
        npre = slow ? 80 : 32;
        // Delimiters written bit 0 in the LSB, a one standing for +1.
        sfd = slow ? 16'hC05E : 16'h392E;
        hdr = {5'h00, len};
        @(negedge mclk);
        start = 1'b1;
        rate_slow = slow;
        pay_len = len;
        // Rate flips and start pulses during the preamble must both be ignored.
        for (k = 0; k < npre; k++) begin
            get_bit(i, q);
            chk("preamble", 16'h0003, {14'h0000, i, q});
            if (k == 0) begin
                rate_slow = ~slow;
                start = 1'b0;
            end
            if (k == 1) start = 1'b1;
        end
        for (k = 0; k < 16; k++) begin
            get_bit(i, q);
            chk("delimiter", {14'h0000, sfd[k], sfd[k]}, {14'h0000, i, q});
        end
        for (k = 0; k < 12; k++) begin
            get_bit(i, q);
            chk("header", {14'h0000, hdr[k], hdr[k]}, {14'h0000, i, q});
        end
        for (k = 0; k < 10; k++) begin
            stall <= (k == 4);
            get_bit(i, q);
            chk("payload", {14'h0000, k[0] ^ k[1] ^ k[3], 1'b0}, {14'h0000, i, q});
        end
        chk("in payload", 16'h0001, 16'(in_payload));
        chk("rate held", 16'(slow), 16'(rate_slow_out));
        chk("symbol bits", slow ? 16'h0006 : 16'h0003, 16'(sym_bits));
        start = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        chk("frame end", 16'h0000, 16'(busy));
    endtask
    task wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(8 * 4000);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        chk("idle", 16'h0003, {busy, bit_valid, 11'h000, sym_bits});
        frame(1'b0, 7'h55);
        frame(1'b1, 7'h7F);
        frame(1'b0, 7'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
